// ===== verif/cpsc_codec_model.sv
/*
  Behavioural codec on the far side of the serial port: serial clock,
  frame sync and the two serial data lines.
  Assumes the bench calls send_frame between clock edges of its own choosing.
*/
`timescale 1ns/1ps
module cpsc_codec_model (
  output logic sclk_o,
  output logic sync_o,
  output logic sdat_p_o,
  output logic sdat_s_o
);
  initial begin
    sclk_o = 1'b0;
    sync_o = 1'b0;
    sdat_p_o = 1'b0;
    sdat_s_o = 1'b1;
  end

  // ----------------------------------------
  // Frame generator
  // ----------------------------------------
  // Clock stands still outside frames; data changes half a period before each rise
  task automatic send_frame(input logic [15:0] w_p, input logic [15:0] w_s, input int nbits);
    #13;
    for (int i = 0; i < nbits; i++) begin
      sync_o = (i == 0);
      sdat_p_o = (i < 16) ? w_p[15 - i] : i[0];
      sdat_s_o = (i < 16) ? w_s[15 - i] : i[1];
      #160 sclk_o = 1'b1;
      #160 sclk_o = 1'b0;
    end
    // Released data lines show the inverse and sync drops low, so stale values never look valid
    sync_o = 1'b0;
    sdat_p_o = ~sdat_p_o;
    sdat_s_o = ~sdat_s_o;
  endtask
endmodule

// ===== verif/cpsc_top_tb.sv
/*
  Self-checking bench of the codec port slot configuration block.
  Assumes the design package and cpsc_params.svh are compiled first.
*/
`timescale 1ns/1ps
`include "cpsc_params.svh"
module cpsc_top_tb;
  logic clk_sys_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic sclk, sync, sd_p, sd_s, strobe, keep, irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] slot_idx;
  cpsc_pkg::cpsc_slot_ctrl_type slot_ctrl;
  cpsc_pkg::cpsc_rx_timing_type rx_timing;
  int mismatches, check_count, strobes;
  int keeps [4];
  logic [5:0] dec [6] = '{6'h08, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20};

  cpsc_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .port_serial_clock_i(sclk), .frame_sync_i(sync), .sdata_primary_i(sd_p),
    .sdata_secondary_i(sd_s), .slot_ctrl_o(slot_ctrl), .rx_timing_o(rx_timing),
    .rx_bit_strobe_o(strobe), .rx_bit_keep_o(keep), .rx_slot_index_o(slot_idx),
    .irq_o(irq));
  cpsc_codec_model codec (.sclk_o(sclk), .sync_o(sync), .sdat_p_o(sd_p), .sdat_s_o(sd_s));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The slave's latency is not assumed; only the watchdog bounds the wait
  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task wreg(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
    chk(32'(err), 32'h00000000);
  endtask

  task rreg(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  task settle();
    repeat (3) @(posedge clk_sys_i);
  endtask

  task frame(input logic [15:0] w_p, input logic [15:0] w_s, input int nbits);
    codec.send_frame(w_p, w_s, nbits);
    repeat (20) @(posedge clk_sys_i);
  endtask

  always @(posedge clk_sys_i) begin
    if (strobe === 1'b1) begin
      strobes++;
      if (keep === 1'b1 && slot_idx < 5'h04) keeps[slot_idx[1:0]]++;
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset();
    chk(32'(slot_ctrl), 32'h00000000);
    chk(32'(irq), 32'h00000000);
    rreg(`CPSC_IDX_RX_TIMING, 32'h00000000);
    rreg(`CPSC_IDX_VALID_HIGH, 32'h00000000);
    rreg(`CPSC_IDX_VALID_LOW, 32'h00000000);
    $display("reset test done");
  endtask

  task t_regs();
    wreg(`CPSC_IDX_VALID_HIGH, 8'hFF);
    rreg(`CPSC_IDX_VALID_HIGH, 32'h0000009F);
    wreg(`CPSC_IDX_VALID_LOW, 8'hFF);
    rreg(`CPSC_IDX_VALID_LOW, 32'h000000F8);
    wreg(`CPSC_IDX_RX_TIMING, 8'hFF);
    rreg(`CPSC_IDX_RX_TIMING, 32'h0000003F);
    rreg(`CPSC_IDX_IRQ_STATUS, 32'h00000008);
    wreg(`CPSC_IDX_IRQ_CLEAR, 8'h08);
    rreg(`CPSC_IDX_IRQ_STATUS, 32'h00000000);
    apb(1'b0, 16'hFFD9, 8'h00);
    chk({err, rd[30:0]}, 32'h80000000);
    chk(32'(slot_ctrl), 32'h00000000);
    $display("register test done");
  endtask

  task t_link();
    wreg(`CPSC_IDX_VALID_HIGH, 8'h91);
    wreg(`CPSC_IDX_VALID_LOW, 8'h88);
    wreg(`CPSC_IDX_LINK_CTRL, 8'h06);
    wreg(`CPSC_IDX_IRQ_ENABLE, 8'h01);
    settle();
    chk(32'(slot_ctrl), 32'h00000631);
    chk(32'(rx_timing), 32'h00000000);
    frame(16'h8000, 16'h8000, 48);
    rreg(`CPSC_IDX_VALID_HIGH, 32'h000000D1);
    chk(32'(irq), 32'h00000001);
    rreg(`CPSC_IDX_IRQ_STATUS, 32'h00000003);
    wreg(`CPSC_IDX_IRQ_ENABLE, 8'h00);
    settle();
    chk(32'(irq), 32'h00000000);
    wreg(`CPSC_IDX_IRQ_CLEAR, 8'h0F);
    rreg(`CPSC_IDX_IRQ_STATUS, 32'h00000000);
    wreg(`CPSC_IDX_LINK_CTRL, 8'h0F);
    frame(16'h0000, 16'h8000, 48);
    rreg(`CPSC_IDX_VALID_HIGH, 32'h000000B1);
    rreg(`CPSC_IDX_IRQ_STATUS, 32'h00000007);
    $display("link test done");
  endtask

  task t_rx();
    wreg(`CPSC_IDX_LINK_CTRL, 8'h05);
    for (int c = 0; c < 6; c++) begin
      wreg(`CPSC_IDX_RX_TIMING, {2'b00, c[2:0], c[2:0]});
      settle();
      chk(32'(rx_timing), 32'({dec[c], dec[c]}));
    end
    // Eight data bits in sixteen-cycle slots
    wreg(`CPSC_IDX_RX_TIMING, 8'h01);
    settle();
    chk(32'(rx_timing), 32'({6'h10, 6'h08}));
    chk(32'(slot_ctrl), 32'h00000000);
    strobes = 0;
    keeps = '{0, 0, 0, 0};
    frame(16'h8000, 16'h0000, 64);
    chk(strobes, 64);
    chk(keeps[0], 8);
    chk(keeps[1], 16);
    chk(keeps[2], 16);
    chk(keeps[3], 8);
    rreg(`CPSC_IDX_VALID_HIGH, 32'h00000091);
    $display("receive timing test done");
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    mismatches++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_regs();
    t_link();
    t_rx();
    finish_test();
  end
endmodule

// ===== verilog/cpsc_params.svh
/*
  Constants of the codec port slot configuration block: register indices,
  field positions, reset values and link mode codes.
  Assumes it is included by its bare name from the top and the bench.
*/
// What this block does
// - High slot-valid register and ready bits act only in the link modes.
// - Bit 7 is a software frame-valid flag: 1 means a valid slot exists.
// - Primary ready follows slot 0 bit 15 from primary codec, each frame.
// - Secondary ready follows slot 0 bit 15 from secondary codec, each frame.
// - Secondary ready means something only with a second codec attached.
// - High register bits 4 down to 0 mark slots 3 through 7 valid.
// - Low register bits 7 down to 3 mark slots 8 through 12 valid.
// - Receive slot timing register is used only in I2S mode 5.
// - Bits per slot code at 5:3 decodes to 8,16,18,20,24,32; rest reserved.
// - Bits per slot does not apply to secondary-communication slots.
// - Slot length code at 2:0 gives 8..32 serial clocks for every slot.
// - Timing register bits 7:6 are reserved, read-only and zero.
`ifndef CPSC_PARAMS_SVH
`define CPSC_PARAMS_SVH

// Register indices; byte address is four times the index
`define CPSC_IDX_RX_TIMING 16'hFFD6
`define CPSC_IDX_VALID_HIGH 16'hFFD7
`define CPSC_IDX_VALID_LOW 16'hFFD8
`define CPSC_IDX_LINK_CTRL 16'hFFE0
`define CPSC_IDX_IRQ_STATUS 16'hFFE1
`define CPSC_IDX_IRQ_CLEAR 16'hFFE2
`define CPSC_IDX_IRQ_ENABLE 16'hFFE3

`define CPSC_RST_RX_TIMING 8'h00
`define CPSC_RST_VALID_HIGH 8'h00
`define CPSC_RST_VALID_LOW 8'h00
`define CPSC_RST_LINK_CTRL 8'h00
`define CPSC_RST_IRQ 4'h0

// Writable masks; other bits are read-only
`define CPSC_WMASK_VALID_HIGH 8'h9F
`define CPSC_WMASK_VALID_LOW 8'hF8
`define CPSC_WMASK_RX_TIMING 8'h3F

`define CPSC_BIT_VF 7
`define CPSC_BIT_PRDY 6
`define CPSC_BIT_SRDY 5
`define CPSC_BIT_SEC_PRESENT 3
`define CPSC_RSVD_CODE_MIN 3'h6

// Link mode codes of the port
`define CPSC_MODE_I2S5 3'h5
`define CPSC_MODE_AC97_A 3'h6
`define CPSC_MODE_AC97_B 3'h7

// Secondary-communication slots
`define CPSC_COMM_SLOT_A 5'h01
`define CPSC_COMM_SLOT_B 5'h02

// Interrupt status bit positions
`define CPSC_IRQ_FRAME 0
`define CPSC_IRQ_PRDY 1
`define CPSC_IRQ_SRDY 2
`define CPSC_IRQ_RSVD 3

`endif

// ===== verilog/cpsc_pkg.sv
/*
  Types of the codec port slot configuration block.
  Assumes cpsc_params.svh is on the include path.
*/
package cpsc_pkg;

  // Slot validity handed to the frame builder (link modes only)
  typedef struct packed {
    logic frame_valid;
    logic [9:0] slot_valid;
  } cpsc_slot_ctrl_type;

  // Receive slot timing handed to the shifter (I2S mode 5 only)
  typedef struct packed {
    logic [5:0] slot_cycles;
    logic [5:0] data_bits;
  } cpsc_rx_timing_type;

  typedef enum logic [1:0] {
    CPSC_ST_HUNT = 2'b01,
    CPSC_ST_RUN = 2'b10
  } cpsc_state_type;

endpackage

// ===== verilog/cpsc_top.sv
/*
  Codec port slot configuration: slot-valid and codec-ready registers,
  receive slot timing, link-side slot counter and interrupt logic on APB.
  Assumes serial clock, frame sync and serial data arrive asynchronously
  from the codec side and are several system clocks per serial bit.
*/
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "cpsc_params.svh"

module cpsc_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [17:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic port_serial_clock_i,
  input wire logic frame_sync_i,
  input wire logic sdata_primary_i,
  input wire logic sdata_secondary_i,
  output cpsc_pkg::cpsc_slot_ctrl_type slot_ctrl_o,
  output cpsc_pkg::cpsc_rx_timing_type rx_timing_o,
  output logic rx_bit_strobe_o,
  output logic rx_bit_keep_o,
  output logic [4:0] rx_slot_index_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Shared decode of the slot length and bits-per-slot codes
  function automatic logic [5:0] decode_width(input logic [2:0] code);
    case (code)
      3'h0: decode_width = 6'h08;
      3'h1: decode_width = 6'h10;
      3'h2: decode_width = 6'h12;
      3'h3: decode_width = 6'h14;
      3'h4: decode_width = 6'h18;
      3'h5: decode_width = 6'h20;
      default: decode_width = 6'h20;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] valid_high_reg;
  logic [7:0] valid_low_reg;
  logic [7:0] rx_timing_reg;
  logic [7:0] link_ctrl_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_enable_reg;
  logic primary_codec_ready_reg;
  logic secondary_codec_ready_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [15:0] idx = paddr_i[17:2];
  wire aligned = (paddr_i[1:0] == 2'h0);
  wire hit_timing = aligned && (idx == `CPSC_IDX_RX_TIMING);
  wire hit_high = aligned && (idx == `CPSC_IDX_VALID_HIGH);
  wire hit_low = aligned && (idx == `CPSC_IDX_VALID_LOW);
  wire hit_ctrl = aligned && (idx == `CPSC_IDX_LINK_CTRL);
  wire hit_stat = aligned && (idx == `CPSC_IDX_IRQ_STATUS);
  wire hit_clr = aligned && (idx == `CPSC_IDX_IRQ_CLEAR);
  wire hit_en = aligned && (idx == `CPSC_IDX_IRQ_ENABLE);
  wire mapped = hit_timing | hit_high | hit_low | hit_ctrl | hit_stat | hit_clr | hit_en;
  wire setup = psel_i && !penable_i;
  wire wr_go = psel_i && penable_i && pready_o && pwrite_i && mapped;
  wire [7:0] wbyte = pwdata_i[7:0];

  wire [7:0] high_view = {valid_high_reg[`CPSC_BIT_VF], primary_codec_ready_reg,
                          secondary_codec_ready_reg, valid_high_reg[4:0]};
  wire [7:0] rdata_sel =
    hit_timing ? {2'h0, rx_timing_reg[5:0]} :
    hit_high ? high_view :
    hit_low ? {valid_low_reg[7:3], 3'h0} :
    hit_ctrl ? {4'h0, link_ctrl_reg[3:0]} :
    hit_stat ? {4'h0, irq_status_reg} :
    hit_en ? {4'h0, irq_enable_reg} : 8'h00;

  // Zero-wait slave: ready is raised for the access phase that follows setup
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !mapped;
      prdata_o <= setup ? {24'h00_0000, rdata_sel} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  wire [7:0] high_next = (valid_high_reg & ~`CPSC_WMASK_VALID_HIGH) |
                         (wbyte & `CPSC_WMASK_VALID_HIGH);
  wire [7:0] low_next = wbyte & `CPSC_WMASK_VALID_LOW;
  wire [7:0] timing_next = wbyte & `CPSC_WMASK_RX_TIMING;
  // Reserved codes are kept as written but flagged to software
  wire rsvd_write = wr_go && hit_timing &&
                    ((wbyte[5:3] >= `CPSC_RSVD_CODE_MIN) ||
                     (wbyte[2:0] >= `CPSC_RSVD_CODE_MIN) ||
                     (decode_width(wbyte[5:3]) > decode_width(wbyte[2:0])));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_high_reg <= `CPSC_RST_VALID_HIGH;
      valid_low_reg <= `CPSC_RST_VALID_LOW;
      rx_timing_reg <= `CPSC_RST_RX_TIMING;
      link_ctrl_reg <= `CPSC_RST_LINK_CTRL;
      irq_enable_reg <= `CPSC_RST_IRQ;
    end else if (wr_go) begin
      if (hit_high) valid_high_reg <= high_next;
      if (hit_low) valid_low_reg <= low_next;
      if (hit_timing) rx_timing_reg <= timing_next;
      if (hit_ctrl) link_ctrl_reg <= {4'h0, wbyte[3:0]};
      if (hit_en) irq_enable_reg <= wbyte[3:0];
    end
  end

  wire [2:0] link_mode = link_ctrl_reg[2:0];
  wire sec_present = link_ctrl_reg[`CPSC_BIT_SEC_PRESENT];
  wire mode_ac97 = (link_mode == `CPSC_MODE_AC97_A) || (link_mode == `CPSC_MODE_AC97_B);
  wire mode_i2s5 = (link_mode == `CPSC_MODE_I2S5);
  wire [5:0] slot_cycles = decode_width(rx_timing_reg[2:0]);
  wire [5:0] data_bits = decode_width(rx_timing_reg[5:3]);

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  // Slot vector: bit 0 is slot 3 ... bit 9 is slot 12
  wire [9:0] slot_map = {valid_low_reg[3], valid_low_reg[4], valid_low_reg[5],
                         valid_low_reg[6], valid_low_reg[7], valid_high_reg[0],
                         valid_high_reg[1], valid_high_reg[2], valid_high_reg[3],
                         valid_high_reg[4]};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_ctrl_o <= '0;
      rx_timing_o <= '0;
    end else begin
      slot_ctrl_o.frame_valid <= mode_ac97 && valid_high_reg[`CPSC_BIT_VF];
      slot_ctrl_o.slot_valid <= mode_ac97 ? slot_map : 10'h000;
      rx_timing_o.slot_cycles <= mode_i2s5 ? slot_cycles : 6'h00;
      rx_timing_o.data_bits <= mode_i2s5 ? data_bits : 6'h00;
    end
  end

  // ----------------------------------------------------------------
  // Link input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclk_sync;
  logic sclk_d;
  logic [1:0] fs_sync;
  logic [1:0] pd_sync;
  logic [1:0] sd_sync;
  logic fs_prev;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_sync <= 2'h0;
      sclk_d <= 1'b0;
      fs_sync <= 2'h0;
      pd_sync <= 2'h0;
      sd_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[0], port_serial_clock_i};
      sclk_d <= sclk_sync[1];
      fs_sync <= {fs_sync[0], frame_sync_i};
      pd_sync <= {pd_sync[0], sdata_primary_i};
      sd_sync <= {sd_sync[0], sdata_secondary_i};
    end
  end

  wire sclk_rise = sclk_sync[1] && !sclk_d;
  wire frame_start = sclk_rise && fs_sync[1] && !fs_prev;

  // ----------------------------------------------------------------
  // Codec ready capture
  // ----------------------------------------------------------------
  // First bit of a frame is bit 15 of slot 0
  wire prdy_next = (mode_ac97 && frame_start) ? pd_sync[1] : primary_codec_ready_reg;
  wire srdy_next = !sec_present ? 1'b0 :
                   (mode_ac97 && frame_start) ? sd_sync[1] : secondary_codec_ready_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_prev <= 1'b0;
      primary_codec_ready_reg <= 1'b0;
      secondary_codec_ready_reg <= 1'b0;
    end else begin
      if (sclk_rise) fs_prev <= fs_sync[1];
      primary_codec_ready_reg <= prdy_next;
      secondary_codec_ready_reg <= srdy_next;
    end
  end

  // ----------------------------------------------------------------
  // Slot counter for I2S mode 5
  // ----------------------------------------------------------------
  cpsc_pkg::cpsc_state_type state_reg;
  cpsc_pkg::cpsc_state_type state_next;
  logic [5:0] slot_bit_reg;
  logic [4:0] slot_idx_reg;

  wire in_run = (state_reg == cpsc_pkg::CPSC_ST_RUN);
  wire bit_tick = sclk_rise && mode_i2s5 && (frame_start || in_run);
  wire [5:0] cur_bit = frame_start ? 6'h00 : slot_bit_reg;
  wire [4:0] cur_slot = frame_start ? 5'h00 : slot_idx_reg;
  wire comm_slot = (cur_slot == `CPSC_COMM_SLOT_A) || (cur_slot == `CPSC_COMM_SLOT_B);
  wire slot_end = (cur_bit == slot_cycles - 6'h01);
  // Audio slots drop bits past the data width; command slots keep all
  wire bit_keep = comm_slot || (cur_bit < data_bits);

  always_comb begin
    case (state_reg)
      cpsc_pkg::CPSC_ST_HUNT: state_next = (mode_i2s5 && frame_start) ?
                                           cpsc_pkg::CPSC_ST_RUN : cpsc_pkg::CPSC_ST_HUNT;
      cpsc_pkg::CPSC_ST_RUN: state_next = mode_i2s5 ?
                                          cpsc_pkg::CPSC_ST_RUN : cpsc_pkg::CPSC_ST_HUNT;
      default: state_next = cpsc_pkg::CPSC_ST_HUNT;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= cpsc_pkg::CPSC_ST_HUNT;
      slot_bit_reg <= 6'h00;
      slot_idx_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      if (bit_tick) begin
        slot_bit_reg <= slot_end ? 6'h00 : cur_bit + 6'h01;
        slot_idx_reg <= slot_end ? cur_slot + 5'h01 : cur_slot;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_bit_strobe_o <= 1'b0;
      rx_bit_keep_o <= 1'b0;
      rx_slot_index_o <= 5'h00;
    end else begin
      rx_bit_strobe_o <= bit_tick;
      rx_bit_keep_o <= bit_tick && bit_keep;
      if (bit_tick) rx_slot_index_o <= cur_slot;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire [3:0] irq_set = {rsvd_write,
                        secondary_codec_ready_reg != srdy_next,
                        primary_codec_ready_reg != prdy_next,
                        mode_ac97 && frame_start};
  wire [3:0] irq_clr = (wr_go && hit_clr) ? wbyte[3:0] : 4'h0;
  // Set beats clear so no event is lost in the clearing cycle
  wire [3:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_reg <= `CPSC_RST_IRQ;
      irq_o <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_o <= |(irq_status_next & irq_enable_reg);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gate_slot_valid: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !mode_ac97 |=> (slot_ctrl_o == '0))
    else $error("slot valid output active outside link modes");

  a_frame_valid_map: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_ac97 |=> (slot_ctrl_o.frame_valid == $past(valid_high_reg[7])))
    else $error("frame valid output does not follow bit 7");

  a_primary_capture: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_ac97 && frame_start) |=> (primary_codec_ready_reg == $past(pd_sync[1])))
    else $error("primary ready not taken from first frame bit");

  a_secondary_capture: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_ac97 && frame_start && sec_present)
      |=> (secondary_codec_ready_reg == $past(sd_sync[1])))
    else $error("secondary ready not taken from first frame bit");

  a_secondary_absent: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !sec_present |=> !secondary_codec_ready_reg)
    else $error("secondary ready set with no second codec");

  a_slot_map_high: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_ac97 ##1 mode_ac97 |-> (slot_ctrl_o.slot_valid[0] == $past(valid_high_reg[4])))
    else $error("slot 3 valid not mapped from bit 4");

  a_slot_map_low: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_ac97 |=> (slot_ctrl_o.slot_valid[9] == $past(valid_low_reg[3])))
    else $error("slot 12 valid not mapped from bit 3");

  a_timing_gate: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !mode_i2s5 |=> (rx_timing_o == '0))
    else $error("slot timing output active outside mode 5");

  a_bits_decode: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_i2s5 && rx_timing_reg[5:3] == 3'h2) |=> (rx_timing_o.data_bits == 6'h12))
    else $error("bits per slot code 2 not decoded as 18");

  a_slot_wrap: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (bit_tick && slot_end) |=> (slot_bit_reg == 6'h00))
    else $error("slot counter did not wrap at slot length");

  a_reserved_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_timing_reg[7:6] == 2'h0)
    else $error("reserved timing bits not zero");

  a_keep_width: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (bit_tick && !comm_slot && cur_bit >= data_bits) |=> (rx_bit_strobe_o && !rx_bit_keep_o))
    else $error("bit beyond data width was kept");

  a_comm_keep: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (bit_tick && comm_slot) |=> rx_bit_keep_o)
    else $error("command slot bit was dropped");

endmodule
